// ---- hdl/hsu_regbank.v ----
// Register bank: keyed unlock of the hidden accuracy setting, run control,
// and held-back loading of the sag level and zero-crossing timeout values.
// Assumes a classic Wishbone master on clk_i and phase samples on clk_i.
//
// Chosen here: the Wishbone register port.
`include "hsu_regs.vh"

// Operation
// - After a good unlock sequence, reading 0xE7E2 returns the value written.
// - Sag and timeout values are initialised at reset, used once run is set.
// - A new sag level may wait, but is adopted once a phase passes 10%.
// - A new timeout may wait, but is adopted once a phase passes 10%.
module hsu_regbank #(
  parameter SAG_W          = 24,
  parameter ZXT_W          = 16,
  parameter ADC_W          = 24,
  parameter ADC_FULL_SCALE = 24'h7FFFFF
)(
  input  wire             clk_i,
  input  wire             rstn_i,
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [17:0]      wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output wire [31:0]      wb_dat_o,
  output wire             wb_ack_o,
  input  wire [ADC_W-1:0] phase_a_v_i,
  input  wire [ADC_W-1:0] phase_b_v_i,
  input  wire [ADC_W-1:0] phase_c_v_i,
  output wire             run_o,
  output wire [SAG_W-1:0] sag_level_threshold_o,
  output wire [ZXT_W-1:0] zero_cross_timeout_o,
  output wire [7:0]       hidden_setting_o
);

  // Bus slave state
  reg         ack_q;
  reg  [31:0] rdat_q;
  reg  [31:0] rdat_d;

  // Hidden setting and its key
  reg  [7:0]  hidden_q;
  reg         key_armed_q;

  // Run control
  reg         run_q;

  // Sag level: shadow as written, active as used by the detector
  reg  [SAG_W-1:0] sag_shadow_q;
  reg  [SAG_W-1:0] sag_active_q;
  reg              sag_pend_q;
  reg  [3:0]       sag_cnt_q;

  // Zero-crossing timeout: shadow and active
  reg  [ZXT_W-1:0] zxt_shadow_q;
  reg  [ZXT_W-1:0] zxt_active_q;
  reg              zxt_pend_q;
  reg  [3:0]       zxt_cnt_q;

  // Sticky record that a phase has passed the release level
  reg              level_seen_q;

  wire             level_over;
  wire [15:0]      idx;
  wire             acc;
  wire             wr;
  wire             sag_wr;
  wire             zxt_wr;
  wire             sag_adopt;
  wire             zxt_adopt;
  wire [31:0]      sag_merged;
  wire [31:0]      zxt_merged;
  wire             key_wr;
  wire             hid_wr;
  wire             run_wr;
  wire             st_wr;

  // Byte-lane merge of a write into an existing word
  function [31:0] lane_merge;
    input [31:0] old_w;
    input [31:0] new_w;
    input [3:0]  sel;
    integer      i;
    begin
      lane_merge = old_w;
      for (i = 0; i < 4; i = i + 1)
        if (sel[i])
          lane_merge[i*8 +: 8] = new_w[i*8 +: 8];
    end
  endfunction

  // Next value of a write counter, saturating at the repeat count
  function [3:0] cnt_next;
    input [3:0] cnt;
    begin
      if (cnt == `HSU_REPEAT_WRITES)
        cnt_next = cnt;
      else
        cnt_next = cnt + 4'h1;
    end
  endfunction

  // Byte write to one word: byte-wide registers need lane 0 enabled
  function byte_hit;
    input        w;
    input [3:0]  sel;
    input [15:0] a;
    input [15:0] target;
    begin
      byte_hit = w & sel[0] & (a == target);
    end
  endfunction

  hsu_level_detect #(
    .ADC_W          (ADC_W),
    .ADC_FULL_SCALE (ADC_FULL_SCALE)
  ) u_level (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .phase_a_v_i (phase_a_v_i),
    .phase_b_v_i (phase_b_v_i),
    .phase_c_v_i (phase_c_v_i),
    .over_o      (level_over)
  );

  // One access per request: taken in the cycle before ack rises, so a
  // held request is never seen twice.
  assign idx    = wb_adr_i[17:2];
  assign acc    = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr     = acc & wb_we_i;
  assign sag_wr = wr & (idx == `HSU_IDX_SAG);
  assign zxt_wr = wr & (idx == `HSU_IDX_ZXT);

  // Write strobes of the byte-wide registers, which live in lane 0
  assign key_wr = byte_hit(wr, wb_sel_i, idx, `HSU_IDX_UNLOCK);
  assign hid_wr = byte_hit(wr, wb_sel_i, idx, `HSU_IDX_HIDDEN);
  assign run_wr = byte_hit(wr, wb_sel_i, idx, `HSU_IDX_RUN);
  assign st_wr  = byte_hit(wr, wb_sel_i, idx, `HSU_IDX_STATUS);

  assign sag_merged = lane_merge({{(32-SAG_W){1'b0}}, sag_shadow_q}, wb_dat_i, wb_sel_i);
  assign zxt_merged = lane_merge({{(32-ZXT_W){1'b0}}, zxt_shadow_q}, wb_dat_i, wb_sel_i);

  // A held value is released by a phase above the level, or by enough
  // repeated writes for hosts that cannot count on line voltage.
  assign sag_adopt = sag_pend_q &
                     (level_over | (sag_cnt_q == `HSU_REPEAT_WRITES));
  assign zxt_adopt = zxt_pend_q &
                     (level_over | (zxt_cnt_q == `HSU_REPEAT_WRITES));

  // Wishbone acknowledge: one cycle after the request, dropped next cycle
  // A registered ack costs a cycle per access but keeps the bus path short
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ack_q <= 1'b0;
    else
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
  end

  // Unlock sequence: only a write that immediately follows the key
  // reaches the hidden setting; any access other than another good key write drops the key.
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hidden_q    <= `HSU_HIDDEN_RST;
      key_armed_q <= 1'b0;
    end
    else if (acc)
    begin
      if (key_armed_q && hid_wr)
        hidden_q <= wb_dat_i[7:0];
      key_armed_q <= key_wr &&
                     (wb_dat_i[7:0] == `HSU_UNLOCK_KEY);
    end
  end

  // Run register
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      run_q <= `HSU_RUN_RST;
    else if (run_wr)
      run_q <= wb_dat_i[`HSU_RUN_BIT];
  end

  // Sag level shadow, pending flag and repeat counter. A write in the
  // same cycle as an adoption wins: the newer value stays pending.
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sag_shadow_q <= `HSU_SAG_RST;
      sag_active_q <= `HSU_SAG_RST;
      sag_pend_q   <= 1'b0;
      sag_cnt_q    <= 4'h0;
    end
    else
    begin
      if (sag_adopt)
        sag_active_q <= sag_shadow_q;
      if (sag_wr)
      begin
        sag_shadow_q <= sag_merged[SAG_W-1:0];
        sag_pend_q   <= 1'b1;
        sag_cnt_q    <= sag_adopt ? 4'h1 : cnt_next(sag_cnt_q);
      end
      else if (sag_adopt)
      begin
        sag_pend_q <= 1'b0;
        sag_cnt_q  <= 4'h0;
      end
    end
  end

  // Zero-crossing timeout shadow, pending flag and repeat counter
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      zxt_shadow_q <= `HSU_ZXT_RST;
      zxt_active_q <= `HSU_ZXT_RST;
      zxt_pend_q   <= 1'b0;
      zxt_cnt_q    <= 4'h0;
    end
    else
    begin
      if (zxt_adopt)
        zxt_active_q <= zxt_shadow_q;
      if (zxt_wr)
      begin
        zxt_shadow_q <= zxt_merged[ZXT_W-1:0];
        zxt_pend_q   <= 1'b1;
        zxt_cnt_q    <= zxt_adopt ? 4'h1 : cnt_next(zxt_cnt_q);
      end
      else if (zxt_adopt)
      begin
        zxt_pend_q <= 1'b0;
        zxt_cnt_q  <= 4'h0;
      end
    end
  end

  // Sticky level record, cleared by writing one to its status bit;
  // a level event in the clearing cycle keeps it set.
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      level_seen_q <= 1'b0;
    else if (level_over)
      level_seen_q <= 1'b1;
    else if (st_wr && wb_dat_i[`HSU_ST_LEVEL_SEEN])
      level_seen_q <= 1'b0;
  end

  // Read multiplexer; unlock key and unmapped words read as zero
  always @*
  begin
    rdat_d = 32'h00000000;
    case (idx)
      `HSU_IDX_HIDDEN:
        rdat_d[7:0] = hidden_q;
      `HSU_IDX_RUN:
        rdat_d[`HSU_RUN_BIT] = run_q;
      `HSU_IDX_SAG:
        rdat_d[SAG_W-1:0] = sag_shadow_q;
      `HSU_IDX_ZXT:
        rdat_d[ZXT_W-1:0] = zxt_shadow_q;
      `HSU_IDX_STATUS:
      begin
        rdat_d[`HSU_ST_SAG_PEND]   = sag_pend_q;
        rdat_d[`HSU_ST_ZXT_PEND]   = zxt_pend_q;
        rdat_d[`HSU_ST_KEY_ARMED]  = key_armed_q;
        rdat_d[`HSU_ST_LEVEL_SEEN] = level_seen_q;
      end
      default:
        rdat_d = 32'h00000000;
    endcase
  end

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdat_q <= 32'h00000000;
    else if (acc && !wb_we_i)
      rdat_q <= rdat_d;
  end

  assign wb_ack_o              = ack_q;
  assign wb_dat_o              = rdat_q;
  assign run_o                 = run_q;
  assign sag_level_threshold_o = sag_active_q;
  assign zero_cross_timeout_o  = zxt_active_q;
  assign hidden_setting_o      = hidden_q;

endmodule

// ---- hdl/hsu_regs.vh ----
// Register indices, field positions, reset values and counts for the
// hidden-setting unlock and threshold-load register bank.
// Assumes a 32-bit classic Wishbone bus; byte address = 4 * index.
`ifndef HSU_REGS_VH
`define HSU_REGS_VH

// Register indices (word index; byte address is four times this)
`define HSU_IDX_HIDDEN      16'hE7E2
`define HSU_IDX_UNLOCK      16'hE7FE
`define HSU_IDX_RUN         16'h0100
`define HSU_IDX_SAG         16'h0101
`define HSU_IDX_ZXT         16'h0102
`define HSU_IDX_STATUS      16'h0103

// Unlock key written to the unlock location
`define HSU_UNLOCK_KEY      8'hAD

// Reset values
`define HSU_HIDDEN_RST      8'h00
`define HSU_RUN_RST         1'b0
`define HSU_SAG_RST         24'h000000
`define HSU_ZXT_RST         16'hFFFF

// Status register bit positions
`define HSU_ST_SAG_PEND     0
`define HSU_ST_ZXT_PEND     1
`define HSU_ST_KEY_ARMED    2
`define HSU_ST_LEVEL_SEEN   3

// Run register bit position
`define HSU_RUN_BIT         0

// Writes after which a held-back value is taken without a level event
`define HSU_REPEAT_WRITES   4'h8

// Phase level, percent of ADC full scale, that releases held-back values
`define HSU_LEVEL_PCT       10

`endif

// ---- hdl/hsu_level_detect.v ----
// Phase voltage level detector: flags when any phase magnitude is above
// a fixed percentage of ADC full scale.
// Assumes samples come from logic on the same clock, so no synchroniser.
`include "hsu_regs.vh"

module hsu_level_detect #(
  parameter ADC_W          = 24,
  parameter ADC_FULL_SCALE = 24'h7FFFFF
)(
  input  wire             clk_i,
  input  wire             rstn_i,
  input  wire [ADC_W-1:0] phase_a_v_i,
  input  wire [ADC_W-1:0] phase_b_v_i,
  input  wire [ADC_W-1:0] phase_c_v_i,
  output wire             over_o
);

  localparam integer     LEVEL_I = (ADC_FULL_SCALE / 100) * `HSU_LEVEL_PCT;
  localparam [ADC_W-1:0] LEVEL   = LEVEL_I[ADC_W-1:0];

  reg over_q;

  // Two's complement magnitude; the most negative code keeps its true size
  function [ADC_W-1:0] mag;
    input [ADC_W-1:0] s;
    begin
      if (s[ADC_W-1])
        mag = ~s + {{(ADC_W-1){1'b0}}, 1'b1};
      else
        mag = s;
    end
  endfunction

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      over_q <= 1'b0;
    else
      over_q <= (mag(phase_a_v_i) > LEVEL) |
                (mag(phase_b_v_i) > LEVEL) |
                (mag(phase_c_v_i) > LEVEL);
  end

  assign over_o = over_q;

endmodule

// ---- verif/hsu_regbank_assertions.sv ----
// Checker bound to hsu_regbank: keyed hidden write and the events
// that may move the run, sag level and timeout outputs.
`include "hsu_regs.vh"
module hsu_regbank_chk #(
  parameter SAG_W          = 24,
  parameter ZXT_W          = 16,
  parameter ADC_W          = 24,
  parameter ADC_FULL_SCALE = 24'h7FFFFF
)(
  input wire             clk_i,
  input wire             rstn_i,
  input wire             wb_cyc_i,
  input wire             wb_stb_i,
  input wire             wb_we_i,
  input wire [17:0]      wb_adr_i,
  input wire [3:0]       wb_sel_i,
  input wire [31:0]      wb_dat_i,
  input wire [31:0]      wb_dat_o,
  input wire             wb_ack_o,
  input wire [ADC_W-1:0] phase_a_v_i,
  input wire [ADC_W-1:0] phase_b_v_i,
  input wire [ADC_W-1:0] phase_c_v_i,
  input wire             run_o,
  input wire [SAG_W-1:0] sag_level_threshold_o,
  input wire [ZXT_W-1:0] zero_cross_timeout_o,
  input wire [7:0]       hidden_setting_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire        rq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr  = rq & wb_we_i;
  wire [15:0] idx = wb_adr_i[17:2];
  reg         key_q;
  function automatic logic ov(input logic [ADC_W-1:0] v);
    logic [ADC_W-1:0] m;
    m = v[ADC_W-1] ? -v : v;
    return m > (ADC_FULL_SCALE / 100) * 10;
  endfunction
  wire over = ov(phase_a_v_i) | ov(phase_b_v_i) | ov(phase_c_v_i);
  // Any access after the key other than another good key write disarms it, so the pair is tracked here
  always @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
      key_q <= 1'b0;
    else if (rq)
      key_q <= wr && idx == `HSU_IDX_UNLOCK && wb_sel_i[0] && wb_dat_i[7:0] == `HSU_UNLOCK_KEY;
  chk_hidden_read: assert property (
    wb_ack_o && $past(rq && !wb_we_i && idx == `HSU_IDX_HIDDEN)
    |-> wb_dat_o[7:0] == hidden_setting_o) else $error("hidden read data wrong");
  chk_hidden_guard: assert property (
    $changed(hidden_setting_o) |-> $past(wr && key_q && idx == `HSU_IDX_HIDDEN))
    else $error("hidden setting moved without key");
  chk_run_source: assert property (
    $changed(run_o) |-> $past(wr && idx == `HSU_IDX_RUN)) else $error("run moved alone");
  chk_sag_adopt: assert property (
    $changed(sag_level_threshold_o) |-> $past(over, 2) || $past(wb_ack_o))
    else $error("sag level adopted without cause");
  chk_zxt_adopt: assert property (
    $changed(zero_cross_timeout_o) |-> $past(over, 2) || $past(wb_ack_o))
    else $error("timeout adopted without cause");
endmodule

bind hsu_regbank hsu_regbank_chk #(
  .SAG_W(SAG_W), .ZXT_W(ZXT_W), .ADC_W(ADC_W), .ADC_FULL_SCALE(ADC_FULL_SCALE)
) u_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phase_a_v_i(phase_a_v_i),
  .phase_b_v_i(phase_b_v_i), .phase_c_v_i(phase_c_v_i), .run_o(run_o),
  .sag_level_threshold_o(sag_level_threshold_o),
  .zero_cross_timeout_o(zero_cross_timeout_o), .hidden_setting_o(hidden_setting_o));

// ---- verif/hsu_host_model.sv ----
// Host model: classic Wishbone master, one access at a time.
// Assumes every request is acked; the bench watchdog cuts a hang.
module hsu_host_model (
  input  wire         clk_i,
  input  wire         ack_i,
  input  wire  [31:0] rdat_i,
  output logic        cyc_o,
  output logic        stb_o,
  output logic        we_o,
  output logic [17:0] adr_o,
  output logic [3:0]  sel_o,
  output logic [31:0] dat_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  // Entered after a rising edge; released data shows its inverse, not a stale copy
  task automatic acc(input logic w, input logic [15:0] i, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] r);
    {cyc_o, stb_o, we_o} <= {2'b11, w};
    adr_o <= {i, 2'b00};
    sel_o <= s;
    dat_o <= d;
    do
      @(posedge clk_i);
    while (ack_i !== 1'b1);
    r = rdat_i;
    {cyc_o, stb_o} <= 2'b00;
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule

// ---- verif/hsu_regbank_test.sv ----
// Bench for the register bank: host model on the bus, phases driven here.
// Assumes the indices and reset values of hsu_regs.vh.
`include "hsu_regs.vh"
module hsu_regbank_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  wire         cyc, stb, we, ack, run;
  wire  [17:0] adr;
  wire  [3:0]  sel;
  wire  [31:0] wdat, rdat;
  wire  [23:0] sag;
  wire  [15:0] zxt;
  wire  [7:0]  hid;
  logic [23:0] pa = '0, pb = '0, pc = '0;
  logic [31:0] r;
  int          err_count = 0, n_checks = 0;

  always #12.5 clk_i = ~clk_i;

  hsu_regbank dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .phase_a_v_i(pa), .phase_b_v_i(pb), .phase_c_v_i(pc), .run_o(run),
    .sag_level_threshold_o(sag), .zero_cross_timeout_o(zxt), .hidden_setting_o(hid));
  hsu_host_model host (
    .clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] i, input logic [3:0] s, input logic [31:0] d);
    host.acc(1'b1, i, s, d, r);
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] e, input string nm);
    host.acc(1'b0, i, 4'h1, 32'h0, r);
    cmp(nm, e, r);
  endtask

  task automatic t_reset;
    cmp("sag", `HSU_SAG_RST, sag);
    cmp("zxt", `HSU_ZXT_RST, zxt);
    rd(`HSU_IDX_UNLOCK, 32'h0, "key read");
    rd(16'h0200, 32'h0, "unmapped read");
  endtask
  task automatic t_broken;
    wr(`HSU_IDX_UNLOCK, 4'h1, 32'hAD);
    rd(`HSU_IDX_RUN, 32'h0, "run read");
    rd(`HSU_IDX_STATUS, 32'h0, "key dropped");
    wr(`HSU_IDX_HIDDEN, 4'h1, 32'h01);
    cmp("hidden split", 8'h00, hid);
    wr(`HSU_IDX_UNLOCK, 4'h1, 32'hAD);
    rd(`HSU_IDX_STATUS, 32'h4, "key armed");
    wr(`HSU_IDX_HIDDEN, 4'h1, 32'h01);
    cmp("hidden after status read", 8'h00, hid);
    wr(`HSU_IDX_UNLOCK, 4'h1, 32'hAC);
    wr(`HSU_IDX_HIDDEN, 4'h1, 32'h01);
    cmp("hidden bad key", 8'h00, hid);
  endtask
  task automatic t_unlock;
    wr(`HSU_IDX_UNLOCK, 4'h1, {24'h0, `HSU_UNLOCK_KEY});
    wr(`HSU_IDX_HIDDEN, 4'h1, 32'h01);
    rd(`HSU_IDX_HIDDEN, 32'h01, "hidden read");
    cmp("hidden out", 8'h01, hid);
  endtask
  task automatic t_level;
    wr(`HSU_IDX_RUN, 4'h1, 32'h1);
    cmp("run", 1'b1, run);
    wr(`HSU_IDX_SAG, 4'hF, 32'h123456);
    wr(`HSU_IDX_ZXT, 4'hF, 32'h0400);
    cmp("sag held", `HSU_SAG_RST, sag);
    cmp("zxt held", `HSU_ZXT_RST, zxt);
    rd(`HSU_IDX_STATUS, 32'h3, "both pending");
    pb <= 24'hF33333;
    repeat (3) @(posedge clk_i);
    cmp("sag on level", 32'h123456, sag);
    cmp("zxt on level", 32'h0400, zxt);
    pb <= 24'h0;
    repeat (3) @(posedge clk_i);
    rd(`HSU_IDX_STATUS, 32'h8, "level seen");
    wr(`HSU_IDX_STATUS, 4'h1, 32'h8);
    rd(`HSU_IDX_STATUS, 32'h0, "level cleared");
  endtask
  task automatic t_repeat;
    for (int k = 0; k < 8; k++)
    begin
      if (k == 7)
      begin
        cmp("sag before eighth", 32'h123456, sag);
        cmp("zxt before eighth", 32'h0400, zxt);
      end
      wr(`HSU_IDX_SAG, 4'hF, 32'h00ABCD);
      wr(`HSU_IDX_ZXT, 4'hF, 32'h1234);
    end
    cmp("sag after eight", 32'h00ABCD, sag);
    cmp("zxt after eight", 32'h1234, zxt);
  endtask
  task automatic t_rerun;
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    cmp("run after reset", `HSU_RUN_RST, run);
    cmp("sag after reset", `HSU_SAG_RST, sag);
    cmp("zxt after reset", `HSU_ZXT_RST, zxt);
    cmp("hidden after reset", `HSU_HIDDEN_RST, hid);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    rd(`HSU_IDX_HIDDEN, {24'h0, `HSU_HIDDEN_RST}, "hidden read after reset");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    t_reset;
    t_broken;
    t_unlock;
    t_level;
    t_repeat;
    t_rerun;
    print_verdict;
  end
  initial
  begin
    #50us;
    err_count++;
    print_verdict;
  end
endmodule
